// [rac_eye_cmp.sv]
// eye-opening threshold comparisons for the adaptation control bank.
// assumes eye measurements are synchronous 8-bit unsigned values.
`timescale 1ns/1ps
module rac_eye_cmp
  import rac_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] horizontal_eye_opening,
  input  wire logic [7:0] vertical_eye_opening,
  input  wire logic [7:0] eye_thr,
  input  wire logic [7:0] hand_thr,
  input  wire logic [1:0] fom_sel,
  output logic            heo_low,
  output logic            veo_low,
  output logic            handoff_ok
);

  logic [7:0] irq_h_lim;
  logic [7:0] irq_v_lim;
  logic [7:0] hand_h_lim;
  logic [7:0] hand_v_lim;
  logic       use_h;
  logic       use_v;

  assign irq_h_lim  = {2'h0, eye_thr[THR_H_LSB +: 4], 2'h0};
  assign irq_v_lim  = {2'h0, eye_thr[THR_V_LSB +: 4], 2'h0};
  assign hand_h_lim = {3'h0, hand_thr[THR_H_LSB +: 4], 1'h0};
  // both handoff limits are checked on the horizontal opening
  assign hand_v_lim = {3'h0, hand_thr[THR_V_LSB +: 4], 1'h0};
  assign use_h      = (fom_sel != FOM_V);
  assign use_v      = (fom_sel != FOM_H);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      heo_low    <= 1'b0;
      veo_low    <= 1'b0;
      handoff_ok <= 1'b0;
    end else begin
      heo_low    <= use_h && (horizontal_eye_opening < irq_h_lim);
      veo_low    <= use_v && (vertical_eye_opening < irq_v_lim);
      handoff_ok <= (!use_h || (horizontal_eye_opening >= hand_h_lim))
                 && (!use_v || (horizontal_eye_opening >= hand_v_lim));
    end
  end

endmodule // rac_eye_cmp

// [rac_pkg.sv]
// package of register indexes, reset values, field positions and codes
// for the adaptation control register bank.
// assumes byte address = 4 * register index on the bus.
package rac_pkg;

  // ---------------------------------------------------------------
  // register indexes
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_LOCKQ   = 6'h2f;
  localparam logic [5:0] IDX_PGEN    = 6'h30;
  localparam logic [5:0] IDX_ADAPT   = 6'h31;
  localparam logic [5:0] IDX_EYE     = 6'h32;
  localparam logic [5:0] IDX_HAND    = 6'h33;
  localparam logic [5:0] IDX_TAPLIM  = 6'h34;
  localparam logic [5:0] IDX_IRQ_ST  = 6'h3e;
  localparam logic [5:0] IDX_IRQ_MSK = 6'h3f;

  // ---------------------------------------------------------------
  // reset values and writable-bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LOCKQ   = 8'h06;
  localparam logic [7:0] RST_PGEN    = 8'h00;
  localparam logic [7:0] RST_ADAPT   = 8'h40;
  localparam logic [7:0] RST_EYE     = 8'h11;
  localparam logic [7:0] RST_HAND    = 8'h88;
  localparam logic [7:0] RST_TAPLIM  = 8'h3f;
  localparam logic [2:0] RST_IRQ     = 3'h0;
  localparam logic [7:0] WM_LOCKQ    = 8'h06;
  localparam logic [7:0] WM_PGEN     = 8'hcf;
  localparam logic [7:0] WM_ADAPT    = 8'hf8;
  localparam logic [7:0] WM_ALL      = 8'hff;
  localparam logic [7:0] WM_TAPLIM   = 8'h7f;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int B_FLD       = 1;
  localparam int B_PPMQ      = 2;
  localparam int B_PCLK      = 3;
  localparam int B_CRU       = 4;
  localparam int B_PPM_RDY   = 7;
  localparam int B_LOWPWR    = 6;
  localparam int MODE_LSB    = 5;
  localparam int FOM_LSB     = 3;
  localparam int THR_H_LSB   = 4;
  localparam int THR_V_LSB   = 0;
  localparam int LOCKCNT_LSB = 4;
  localparam int IRQ_CRU     = 0;
  localparam int IRQ_HEO     = 1;
  localparam int IRQ_VEO     = 2;
  localparam int N_IRQ       = 3;
  localparam int N_TAPS      = 4;
  localparam int TAP_W       = 5;

  // ---------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF         = 2'h0,
    MODE_LIN         = 2'h1,
    MODE_LIN_FB_LIN  = 2'h2,
    MODE_LOCK_FB_LIN = 2'h3
  } rac_mode_t;

  typedef enum logic [1:0] {
    FOM_BOTH   = 2'h0,
    FOM_H      = 2'h1,
    FOM_V      = 2'h2,
    FOM_BOTH_B = 2'h3
  } rac_fom_t;

endpackage

// [rac_regs.sv]
// adaptation control register bank for one retimer channel.
// assumes an avalon-mm master on sys_clk and synchronous status inputs.
// Behaviour
// - read/write bit, default one, enables frequency lock detect as lock qualifier
// - read/write bit, default one, enables frequency offset count as lock qualifier
// - bit 4 at pattern_gen_and_recovery_irq is read-only, high when clock recovery interrupt is high
// - pattern_gen_and_recovery_irq bit 3 gates pattern generator clock, bits 1:0 pick pattern
// - adaptation mode bits 6:5, reset 10, four adaptation sequences
// - bits 4:3 pick figure of merit: both, horizontal only, vertical only
// - horizontal eye interrupt compares opening against four times bits 7:4
// - vertical eye interrupt compares opening against four times bits 3:0
// - linear to feedback handoff compares horizontal opening to twice bits 7:4
// - second handoff threshold bits 3:0, twice value, on horizontal opening
// - feedback taps two to five clamped to magnitude in bits 3:0
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module rac_regs
  import rac_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic [7:0]                   address,
  input  wire logic                         read,
  input  wire logic                         write,
  input  wire logic [7:0]                   writedata,
  output logic      [7:0]                   readdata,
  output logic                              waitrequest,
  input  wire logic                         clock_recovery_irq,
  input  wire logic                         ppm_error_ready,
  input  wire logic [7:0]                   horizontal_eye_opening,
  input  wire logic [7:0]                   vertical_eye_opening,
  input  wire logic [N_TAPS-1:0][TAP_W-1:0] fb_tap_req,
  output logic      [N_TAPS-1:0][TAP_W-1:0] fb_tap_lim,
  output logic                              fld_check_en,
  output logic                              ppm_check_en,
  output logic                              pattern_clk_en,
  output logic      [1:0]                   pattern_sel,
  output rac_mode_t                         adapt_mode,
  output logic      [1:0]                   fom_sel,
  output logic      [7:0]                   eye_thr,
  output logic      [7:0]                   hand_thr,
  output logic                              low_power_dis,
  output logic      [1:0]                   lock_count,
  output logic                              handoff_ready,
  output logic                              irq
);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic [7:0]       lockq;
  logic [7:0]       pgen;
  logic [7:0]       adapt;
  logic [7:0]       taplim;
  logic [N_IRQ-1:0] irq_status;
  logic [N_IRQ-1:0] irq_mask;
  logic [N_IRQ-1:0] irq_set;
  logic [N_IRQ-1:0] rd_clr;
  logic [5:0]       idx;
  logic             aligned;
  logic             commit;
  logic             wr_en;
  logic             rd_done;
  logic [7:0]       next_readdata;
  logic             cru_q;
  logic             cru_prev;
  logic             ppm_rdy_q;
  logic             heo_low;
  logic             veo_low;
  logic             heo_prev;
  logic             veo_prev;
  logic             handoff_ok;

  assign idx     = address[7:2];
  assign aligned = (address[1:0] == 2'h0);
  // a request waits one cycle, then completes while waitrequest is low
  assign commit  = (read || write) && !waitrequest;
  assign wr_en   = commit && write && aligned;
  assign rd_done = commit && read && aligned && (idx == IDX_IRQ_ST);

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (new_v & mask) | (old_v & ~mask);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
    end
  end

  always_comb begin
    next_readdata = 8'h00;
    if (aligned) begin
      unique case (idx)
        IDX_LOCKQ:   next_readdata = lockq;
        IDX_PGEN:    next_readdata = pgen | (8'(cru_q) << B_CRU);
        IDX_ADAPT:   next_readdata = adapt;
        IDX_EYE:     next_readdata = eye_thr;
        IDX_HAND:    next_readdata = hand_thr;
        IDX_TAPLIM:  next_readdata = taplim | (8'(ppm_rdy_q) << B_PPM_RDY);
        IDX_IRQ_ST:  next_readdata = {5'h00, irq_status};
        IDX_IRQ_MSK: next_readdata = {5'h00, irq_mask};
        default:     next_readdata = 8'h00;
      endcase
    end
  end

  // data are latched when the request is first seen, stable to completion
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readdata <= 8'h00;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lockq <= RST_LOCKQ;
    end else if (wr_en && idx == IDX_LOCKQ) begin
      lockq <= merge(lockq, writedata, WM_LOCKQ);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pgen <= RST_PGEN;
    end else if (wr_en && idx == IDX_PGEN) begin
      pgen <= merge(pgen, writedata, WM_PGEN);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      adapt <= RST_ADAPT;
    end else if (wr_en && idx == IDX_ADAPT) begin
      adapt <= merge(adapt, writedata, WM_ADAPT);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eye_thr <= RST_EYE;
    end else if (wr_en && idx == IDX_EYE) begin
      eye_thr <= merge(eye_thr, writedata, WM_ALL);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hand_thr <= RST_HAND;
    end else if (wr_en && idx == IDX_HAND) begin
      hand_thr <= merge(hand_thr, writedata, WM_ALL);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      taplim <= RST_TAPLIM;
    end else if (wr_en && idx == IDX_TAPLIM) begin
      taplim <= merge(taplim, writedata, WM_TAPLIM);
    end
  end

  assign fld_check_en   = lockq[B_FLD];
  assign ppm_check_en   = lockq[B_PPMQ];
  assign pattern_clk_en = pgen[B_PCLK];
  assign pattern_sel    = pgen[1:0];
  assign adapt_mode     = rac_mode_t'(adapt[MODE_LSB +: 2]);
  assign fom_sel        = adapt[FOM_LSB +: 2];
  assign low_power_dis  = taplim[B_LOWPWR];
  assign lock_count     = taplim[LOCKCNT_LSB +: 2];

  // ---------------------------------------------------------------
  // status sampling and eye comparisons
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cru_q     <= 1'b0;
      cru_prev  <= 1'b0;
      ppm_rdy_q <= 1'b0;
      heo_prev  <= 1'b0;
      veo_prev  <= 1'b0;
    end else begin
      cru_q     <= clock_recovery_irq;
      cru_prev  <= cru_q;
      ppm_rdy_q <= ppm_error_ready;
      heo_prev  <= heo_low;
      veo_prev  <= veo_low;
    end
  end

  rac_eye_cmp u_eye_cmp (
    .sys_clk                (sys_clk),
    .rst                    (rst),
    .horizontal_eye_opening (horizontal_eye_opening),
    .vertical_eye_opening   (vertical_eye_opening),
    .eye_thr                (eye_thr),
    .hand_thr               (hand_thr),
    .fom_sel                (fom_sel),
    .heo_low                (heo_low),
    .veo_low                (veo_low),
    .handoff_ok             (handoff_ok)
  );

  assign handoff_ready = handoff_ok;

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  assign irq_set[IRQ_CRU] = cru_q && !cru_prev;
  assign irq_set[IRQ_HEO] = heo_low && !heo_prev;
  assign irq_set[IRQ_VEO] = veo_low && !veo_prev;
  // only bits already returned to software are cleared; a new set wins
  assign rd_clr = rd_done ? readdata[N_IRQ-1:0] : RST_IRQ;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_status <= RST_IRQ;
    end else begin
      irq_status <= (irq_status & ~rd_clr) | irq_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask <= RST_IRQ;
    end else if (wr_en && idx == IDX_IRQ_MSK) begin
      irq_mask <= writedata[N_IRQ-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // feedback tap clamp, taps two to five
  // ---------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < N_TAPS; t++) begin : g_tap
      logic [TAP_W-1:0] mag;
      logic [TAP_W-1:0] lim;
      assign mag = fb_tap_req[t][TAP_W-1] ? TAP_W'(-fb_tap_req[t]) : fb_tap_req[t];
      assign lim = {1'b0, taplim[3:0]};
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          fb_tap_lim[t] <= '0;
        end else if (mag > lim) begin
          fb_tap_lim[t] <= fb_tap_req[t][TAP_W-1] ? TAP_W'(-lim) : lim;
        end else begin
          fb_tap_lim[t] <= fb_tap_req[t];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  fld_default_a: assert property ($fell(rst) |-> fld_check_en)
    else $error("lock detect qualifier not set after reset");
  ppm_default_a: assert property ($fell(rst) |-> ppm_check_en)
    else $error("offset qualifier not set after reset");
  cru_status_a: assert property ($rose(clock_recovery_irq) |-> ##2 irq_status[IRQ_CRU])
    else $error("clock recovery event not recorded");
  pattern_write_a: assert property (wr_en && idx == IDX_PGEN |=>
      pattern_sel == $past(writedata[1:0]) && pattern_clk_en == $past(writedata[B_PCLK]))
    else $error("pattern control write lost");
  mode_reset_a: assert property ($fell(rst) |-> adapt_mode == MODE_LIN_FB_LIN)
    else $error("adaptation mode reset wrong");
  heo_thr_a: assert property (fom_sel == FOM_H |=>
      heo_low == ($past(horizontal_eye_opening) < {2'h0, $past(eye_thr[7:4]), 2'h0}))
    else $error("horizontal eye compare wrong");
  veo_thr_a: assert property (fom_sel == FOM_V |=>
      veo_low == ($past(vertical_eye_opening) < {2'h0, $past(eye_thr[3:0]), 2'h0}) && !heo_low)
    else $error("vertical eye compare wrong");
  handoff_h_a: assert property (fom_sel == FOM_H |=>
      handoff_ready == ($past(horizontal_eye_opening) >= {3'h0, $past(hand_thr[7:4]), 1'h0}))
    else $error("handoff compare wrong");
  handoff_v_a: assert property (fom_sel == FOM_V |=>
      handoff_ready == ($past(horizontal_eye_opening) >= {3'h0, $past(hand_thr[3:0]), 1'h0}))
    else $error("second handoff compare wrong");
  tap_clamp_a: assert property (!fb_tap_lim[0][TAP_W-1] |-> fb_tap_lim[0][3:0] <= $past(taplim[3:0]))
    else $error("feedback tap exceeds limit");
  status_hold_a: assert property (irq_status[IRQ_HEO] && !rd_done |=> irq_status[IRQ_HEO])
    else $error("eye status lost without read");
  irq_out_a: assert property (##1 irq == $past(|(irq_status & irq_mask)))
    else $error("interrupt output mismatch");

endmodule // rac_regs

// [test_rac_regs.sv]
// self-checking bench for the adaptation control register bank.
// assumes a lone rac_regs; the bench drives every port itself.
`timescale 1ns/1ps
module test_rac_regs
  import rac_pkg::*;
;
  logic                         sys_clk, rst, read, write, waitrequest, irq;
  logic [7:0]                   address, writedata, readdata, rd;
  logic                         clock_recovery_irq, ppm_error_ready;
  logic [7:0]                   horizontal_eye_opening, vertical_eye_opening;
  logic [N_TAPS-1:0][TAP_W-1:0] fb_tap_req, fb_tap_lim;
  logic                         fld_check_en, ppm_check_en, pattern_clk_en;
  logic [1:0]                   pattern_sel, fom_sel, lock_count;
  rac_mode_t                    adapt_mode;
  logic [7:0]                   eye_thr, hand_thr;
  logic                         low_power_dis, handoff_ready;
  int                           miscompares, samples_checked;

  rac_regs i_dut (.sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .clock_recovery_irq(clock_recovery_irq), .ppm_error_ready(ppm_error_ready),
    .horizontal_eye_opening(horizontal_eye_opening),
    .vertical_eye_opening(vertical_eye_opening), .fb_tap_req(fb_tap_req),
    .fb_tap_lim(fb_tap_lim), .fld_check_en(fld_check_en), .ppm_check_en(ppm_check_en),
    .pattern_clk_en(pattern_clk_en), .pattern_sel(pattern_sel), .adapt_mode(adapt_mode),
    .fom_sel(fom_sel), .eye_thr(eye_thr), .hand_thr(hand_thr),
    .low_power_dis(low_power_dis), .lock_count(lock_count),
    .handoff_ready(handoff_ready), .irq(irq));

  // ---------------------------------------------------------------
  // clock, closing and comparison
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // avalon-mm master: hold until waitrequest is seen low
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                     output logic [7:0] d);
    int n;
    n = 0;
    address   <= addr;
    writedata <= wd;
    write     <= wr;
    read      <= ~wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      miscompares++;
      $display("wrong value at %0t: no answer on the bus", $time);
    end
    d = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    // one idle edge so no signal is assigned twice in a time step
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, {idx, 2'b00}, wd, d);
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bus(1'b0, {idx, 2'b00}, 8'h00, d);
    chk(d, exp, what);
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    $display("wrong value at %0t: run did not finish", $time);
    give_verdict();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1; read = 1'b0; write = 1'b0; address = 8'h00; writedata = 8'h00;
    clock_recovery_irq = 1'b0; ppm_error_ready = 1'b0; fb_tap_req = '0;
    horizontal_eye_opening = 8'hff; vertical_eye_opening = 8'hff;
    miscompares = 0; samples_checked = 0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);

    rchk(IDX_LOCKQ, 8'h06, "lock qualifiers reset");
    rchk(IDX_PGEN, 8'h00, "pattern reg reset");
    rchk(IDX_ADAPT, 8'h40, "adapt config reset");
    rchk(IDX_EYE, 8'h11, "eye thresholds reset");
    rchk(IDX_HAND, 8'h88, "handoff thresholds reset");
    rchk(IDX_TAPLIM, 8'h3f, "tap limit reset");
    chk({6'h0, adapt_mode}, 8'h02, "adapt_mode reset");
    chk({6'h0, fld_check_en, ppm_check_en}, 8'h03, "qualifier outputs");
    $display("test reset values done");

    wr(IDX_LOCKQ, 8'h00);
    chk({6'h0, fld_check_en, ppm_check_en}, 8'h00, "qualifiers off");
    rchk(IDX_LOCKQ, 8'h00, "qualifiers cleared");
    wr(IDX_LOCKQ, 8'hff);
    rchk(IDX_LOCKQ, 8'h06, "qualifiers set, bit0 reads 0");
    rchk(6'h14, 8'h00, "unmapped read");
    wr(6'h14, 8'hff);
    // misaligned write lands on the pattern register index if decoded wrongly
    bus(1'b1, 8'hc1, 8'hff, rd);
    bus(1'b0, {IDX_PGEN, 2'b00}, 8'h00, rd);
    chk(rd, 8'h00, "pattern reg after stray writes");
    // misaligned read of the lock qualifier index, which holds 06
    bus(1'b0, 8'hbd, 8'h00, rd);
    chk(rd, 8'h00, "misaligned read");
    $display("test qualifiers and decoding done");

    wr(IDX_IRQ_MSK, 8'h07);
    rchk(IDX_IRQ_MSK, 8'h07, "mask readback");
    clock_recovery_irq <= 1'b1;
    pause(4);
    chk({7'h0, irq}, 8'h01, "irq on recovery event");
    rchk(IDX_PGEN, 8'h10, "recovery bit visible");
    wr(IDX_PGEN, 8'h30);
    rchk(IDX_PGEN, 8'h10, "recovery bit ignores write");
    rchk(IDX_IRQ_ST, 8'h01, "status after recovery event");
    clock_recovery_irq <= 1'b0;
    pause(3);
    chk({7'h0, irq}, 8'h00, "irq after read-clear");
    rchk(IDX_IRQ_ST, 8'h00, "status cleared");
    rchk(IDX_PGEN, 8'h00, "recovery bit follows input");
    wr(IDX_IRQ_MSK, 8'h00);
    clock_recovery_irq <= 1'b1;
    pause(4);
    chk({7'h0, irq}, 8'h00, "masked irq stays low");
    rchk(IDX_IRQ_ST, 8'h01, "masked event still sticky");
    clock_recovery_irq <= 1'b0;
    pause(2);
    $display("test recovery interrupt done");

    wr(IDX_PGEN, 8'hff);
    rchk(IDX_PGEN, 8'hcf, "pattern reg writable bits");
    chk({5'h0, pattern_clk_en, pattern_sel}, 8'h07, "pattern outputs on");
    wr(IDX_PGEN, 8'h02);
    chk({5'h0, pattern_clk_en, pattern_sel}, 8'h02, "pattern outputs sel");
    for (int m = 0; m < 4; m++) begin
      wr(IDX_ADAPT, 8'(m * 32 + (3 - m) * 8 + 7));
      chk({6'h0, adapt_mode}, 8'(m), "adapt_mode code");
      chk({6'h0, fom_sel}, 8'(3 - m), "fom_sel code");
      rchk(IDX_ADAPT, 8'(m * 32 + (3 - m) * 8), "adapt readback");
    end
    $display("test pattern and adaptation modes done");

    wr(IDX_ADAPT, 8'h40);
    wr(IDX_IRQ_MSK, 8'h06);
    wr(IDX_EYE, 8'h23);
    chk(eye_thr, 8'h23, "eye_thr output");
    horizontal_eye_opening <= 8'h08;
    pause(4);
    chk({7'h0, irq}, 8'h00, "horizontal at threshold");
    horizontal_eye_opening <= 8'h07;
    pause(4);
    chk({7'h0, irq}, 8'h01, "horizontal below threshold");
    horizontal_eye_opening <= 8'hff;
    pause(4);
    rchk(IDX_IRQ_ST, 8'h02, "horizontal eye status");
    vertical_eye_opening <= 8'h0c;
    pause(4);
    rchk(IDX_IRQ_ST, 8'h00, "vertical at threshold");
    vertical_eye_opening <= 8'h0b;
    pause(4);
    vertical_eye_opening <= 8'hff;
    pause(4);
    rchk(IDX_IRQ_ST, 8'h04, "vertical eye status");
    wr(IDX_ADAPT, 8'h48);
    vertical_eye_opening <= 8'h00;
    pause(4);
    vertical_eye_opening <= 8'hff;
    pause(4);
    rchk(IDX_IRQ_ST, 8'h00, "vertical ignored, horizontal only");
    wr(IDX_ADAPT, 8'h40);
    $display("test eye interrupts done");

    wr(IDX_HAND, 8'h44);
    chk(hand_thr, 8'h44, "hand_thr output");
    horizontal_eye_opening <= 8'h08;
    pause(4);
    chk({7'h0, handoff_ready}, 8'h01, "handoff at twice threshold");
    horizontal_eye_opening <= 8'h07;
    pause(4);
    chk({7'h0, handoff_ready}, 8'h00, "no handoff below");
    // unequal limits tell the two handoff fields apart
    wr(IDX_HAND, 8'h41);
    wr(IDX_ADAPT, 8'h50);
    pause(2);
    chk({7'h0, handoff_ready}, 8'h01, "second handoff limit");
    wr(IDX_ADAPT, 8'h48);
    pause(2);
    chk({7'h0, handoff_ready}, 8'h00, "first handoff limit");
    wr(IDX_ADAPT, 8'h40);
    horizontal_eye_opening <= 8'hff;
    $display("test handoff done");

    ppm_error_ready <= 1'b1;
    wr(IDX_TAPLIM, 8'hff);
    rchk(IDX_TAPLIM, 8'hff, "tap reg with ready bit");
    chk({5'h0, low_power_dis, lock_count}, 8'h07, "low power and lock count");
    wr(IDX_TAPLIM, 8'h05);
    fb_tap_req <= {5'h10, 5'h03, 5'h17, 5'h09};
    pause(3);
    chk({3'h0, fb_tap_lim[0]}, 8'h05, "tap positive clamp");
    chk({3'h0, fb_tap_lim[1]}, 8'h1b, "tap negative clamp");
    chk({3'h0, fb_tap_lim[2]}, 8'h03, "tap within limit");
    chk({3'h0, fb_tap_lim[3]}, 8'h1b, "tap most negative");
    $display("test tap limits done");
    give_verdict();
  end
endmodule // test_rac_regs
